// ---- logic/psm_sync_mem_if.sv ----
`timescale 1ns/1ps
// Overview of operation
// - read latency 0 to 3 cycles, programmable
// - write latency 0 to 3 cycles, programmable
// - extension off: chip select drops after command
// - extension on: chip select follows output enable
// - strobe mode 0: address strobe, deselect cycles
// - strobe mode 1: fifo read enable, no deselect
// - interface runs on one of two clocks
// - settings held in secondary control register
// - read data captured on selected rising edge
// - pins change only on selected rising edge
// - shared pins act as strobe, oe, we
module psm_sync_mem_if
    import psm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // secondary control load
    input wire logic cfg_load_in,
    input wire logic [CFG_W-1:0] cfg_in,
    output logic cfg_ready_out,
    output logic [CFG_W-1:0] space_secondary_control_out,
    // request stream
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [BE_W-1:0] req_be_in,
    input wire logic [DATA_W-1:0] req_data_in,
    output logic req_ready_out,
    // read return
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rd_data_out,
    // external clocks
    output logic ext_clock_out_one,
    output logic ext_clock_out_two,
    // memory pins
    output logic chip_select_n_out,
    output logic [BE_W-1:0] byte_enable_n_out,
    output logic [ADDR_W-1:0] ext_addr_bus_out,
    output logic addr_strobe_or_read_en_n_out,
    output logic sync_output_en_n_out,
    output logic sync_write_en_n_out,
    input wire logic [DATA_W-1:0] ext_data_bus_in,
    output logic [DATA_W-1:0] ext_data_bus_out,
    output logic ext_data_bus_oe_out
);
    psm_stream_if #(.W(REQ_W)) q ();

    logic [1:0] div_r;
    logic [CFG_W-1:0] cfg_r;
    psm_state_t state_r;
    logic [2:0] age_r;
    logic [1:0] lat_r;
    logic wr_r;
    logic rd_valid_r;
    logic [DATA_W-1:0] rd_data_r;
    logic tick_w;
    logic done_w;
    logic start_w;
    logic ext_w;
    logic ren_w;
    psm_req_t head_w;
    psm_req_t req_w;

    // request buffer
    assign req_w = '{wr: req_write_in, be: req_be_in, addr: req_addr_in, data: req_data_in};
    assign q.in_valid = req_valid_in;
    assign q.in_data = req_w;
    assign req_ready_out = q.in_ready;
    assign head_w = psm_req_t'(q.out_data);
    assign q.out_ready = start_w;

    psm_fifo #(.W(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .q(q)
    );

    // clock dividers for both external clocks
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            div_r <= DIV_RESET;
        else
            div_r <= div_r + 2'h1;
    end
    assign ext_clock_out_one = div_r[0];
    assign ext_clock_out_two = div_r[1];

    // rising edge of the selected clock is due at this core edge
    assign tick_w = cfg_r[CFG_CLK_BIT] ? (div_r == 2'h1) : !div_r[0];

    // secondary control register, loadable only between accesses
    assign cfg_ready_out = (state_r == PSM_IDLE) && !q.out_valid;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            cfg_r <= CFG_RESET;
        else if (cfg_load_in && cfg_ready_out)
            cfg_r <= cfg_in;
    end
    assign space_secondary_control_out = cfg_r;
    assign ext_w = cfg_r[CFG_EXT_BIT];
    assign ren_w = cfg_r[CFG_REN_BIT];

    // access sequencing
    assign done_w = tick_w && (state_r == PSM_ACC) && (age_r == {1'b0, lat_r});
    assign start_w = tick_w && q.out_valid && ((state_r == PSM_IDLE) || (done_w && ren_w));

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r <= PSM_IDLE;
            age_r <= AGE_RESET;
            lat_r <= 2'h0;
            wr_r <= 1'b0;
        end
        else if (start_w)
        begin
            state_r <= PSM_ACC;
            age_r <= AGE_RESET;
            wr_r <= head_w.wr;
            lat_r <= head_w.wr ? cfg_r[CFG_WL_LSB +: 2] : cfg_r[CFG_RL_LSB +: 2];
        end
        else if (tick_w)
        begin
            unique case (state_r)
                PSM_IDLE: state_r <= PSM_IDLE;
                PSM_ACC:
                begin
                    age_r <= age_r + 3'h1;
                    if (done_w)
                        state_r <= ren_w ? PSM_IDLE : PSM_DESEL;
                end
                PSM_DESEL: state_r <= PSM_IDLE;
                default: state_r <= PSM_IDLE;
            endcase
        end
    end

    // memory pins, updated only on selected clock edges
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            chip_select_n_out <= 1'b1;
            byte_enable_n_out <= '1;
            ext_addr_bus_out <= '0;
            addr_strobe_or_read_en_n_out <= 1'b1;
            sync_output_en_n_out <= 1'b1;
            sync_write_en_n_out <= 1'b1;
            ext_data_bus_out <= '0;
            ext_data_bus_oe_out <= 1'b0;
        end
        else if (start_w)
        begin
            chip_select_n_out <= 1'b0;
            byte_enable_n_out <= ~head_w.be;
            ext_addr_bus_out <= head_w.addr;
            addr_strobe_or_read_en_n_out <= 1'b0;
            sync_output_en_n_out <= head_w.wr;
            sync_write_en_n_out <= !head_w.wr;
            ext_data_bus_out <= head_w.data;
            ext_data_bus_oe_out <= head_w.wr && (cfg_r[CFG_WL_LSB +: 2] == 2'h0);
        end
        else if (tick_w && (state_r == PSM_ACC))
        begin
            addr_strobe_or_read_en_n_out <= 1'b1;
            sync_write_en_n_out <= 1'b1;
            if (done_w)
            begin
                chip_select_n_out <= 1'b1;
                sync_output_en_n_out <= 1'b1;
                ext_data_bus_oe_out <= 1'b0;
            end
            else
            begin
                chip_select_n_out <= !(ext_w && !wr_r);
                ext_data_bus_oe_out <= ext_data_bus_oe_out
                    || (wr_r && (age_r + 3'h1 == {1'b0, lat_r}));
            end
        end
    end

    // read data capture at the programmed latency
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end
        else
        begin
            rd_valid_r <= done_w && !wr_r;
            if (done_w && !wr_r)
                rd_data_r <= ext_data_bus_in;
        end
    end
    assign rd_valid_out = rd_valid_r;
    assign rd_data_out = rd_data_r;

    // checks
    property p_rd_lat;
        @(posedge core_clk_in) disable iff (rst_in)
        rd_valid_out |-> ($past(age_r) == {1'b0, $past(lat_r)}) && !$past(wr_r);
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read captured off latency");

    property p_wr_lat;
        @(posedge core_clk_in) disable iff (rst_in)
        $rose(ext_data_bus_oe_out) |-> wr_r && (age_r == {1'b0, lat_r});
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write data off latency");

    property p_cs_short;
        @(posedge core_clk_in) disable iff (rst_in)
        (state_r == PSM_ACC && age_r != 3'h0 && !ext_w) |-> chip_select_n_out;
    endproperty
    a_cs_short: assert property (p_cs_short) else $error("chip select held");

    property p_cs_ext;
        @(posedge core_clk_in) disable iff (rst_in)
        (ext_w && !sync_output_en_n_out) |-> !chip_select_n_out;
    endproperty
    a_cs_ext: assert property (p_cs_ext) else $error("chip select dropped early");

    property p_desel;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_w && !ren_w) |=> (state_r == PSM_DESEL) && chip_select_n_out
            && addr_strobe_or_read_en_n_out;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect cycle missing");

    property p_no_desel;
        @(posedge core_clk_in) disable iff (rst_in)
        (done_w && ren_w && q.out_valid) |=> !addr_strobe_or_read_en_n_out;
    endproperty
    a_no_desel: assert property (p_no_desel) else $error("gap in fifo mode");

    property p_clk_sel;
        @(posedge core_clk_in) disable iff (rst_in)
        tick_w |=> ($past(cfg_r[CFG_CLK_BIT]) ? ext_clock_out_two : ext_clock_out_one);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("tick off selected clock");

    property p_cfg;
        @(posedge core_clk_in) disable iff (rst_in)
        (cfg_load_in && cfg_ready_out) |=> space_secondary_control_out == $past(cfg_in);
    endproperty
    a_cfg: assert property (p_cfg) else $error("control register not loaded");

    property p_capture;
        @(posedge core_clk_in) disable iff (rst_in)
        rd_valid_out |-> rd_data_out == $past(ext_data_bus_in);
    endproperty
    a_capture: assert property (p_capture) else $error("wrong read data");

    property p_pin_edge;
        @(posedge core_clk_in) disable iff (rst_in)
        ($changed(ext_addr_bus_out) || $changed(chip_select_n_out)) |-> $past(tick_w);
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("pin moved off edge");
endmodule : psm_sync_mem_if

// ---- pkg/psm_pkg.sv ----
package psm_pkg;
    // data path widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 20;
    localparam int BE_W = 4;
    localparam int FIFO_DEPTH = 16;
    // secondary control layout: [1:0] rd lat, [3:2] wr lat, [4] cs ext, [5] ren mode, [6] clk sel
    localparam int CFG_W = 7;
    localparam int CFG_RL_LSB = 0;
    localparam int CFG_WL_LSB = 2;
    localparam int CFG_EXT_BIT = 4;
    localparam int CFG_REN_BIT = 5;
    localparam int CFG_CLK_BIT = 6;
    localparam logic [6:0] CFG_RESET = 7'h00;
    // clock outputs: one is core/2, two is core/4
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [2:0] AGE_RESET = 3'h0;

    typedef enum logic [1:0]
    {
        PSM_IDLE = 2'b00,
        PSM_ACC = 2'b01,
        PSM_DESEL = 2'b10
    } psm_state_t;

    typedef struct packed
    {
        logic wr;
        logic [BE_W-1:0] be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } psm_req_t;

    localparam int REQ_W = $bits(psm_req_t);
endpackage : psm_pkg

// ---- pkg/psm_stream_if.sv ----
`timescale 1ns/1ps
interface psm_stream_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport fifo_mp (input in_valid, input in_data, input out_ready,
                     output in_ready, output out_valid, output out_data);
    modport user_mp (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface : psm_stream_if

// ---- logic/psm_fifo.sv ----
`timescale 1ns/1ps
module psm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // both sides
    psm_stream_if.fifo_mp q
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [PW:0] wr_ptr_r;
    logic [PW:0] rd_ptr_r;
    logic out_valid_r;
    logic [W-1:0] out_data_r;
    logic [PW:0] count_w;
    logic push_w;
    logic load_w;

    // occupancy and handshakes
    assign count_w = wr_ptr_r - rd_ptr_r;
    assign q.in_ready = (count_w != DEPTH[PW:0]);
    assign push_w = q.in_valid && q.in_ready;
    assign load_w = (count_w != '0) && (!out_valid_r || q.out_ready);
    assign q.out_valid = out_valid_r;
    assign q.out_data = out_data_r;

    // storage array, one write port
    always_ff @(posedge core_clk_in)
    begin
        if (push_w)
        begin
            mem_r[wr_ptr_r[PW-1:0]] <= q.in_data;
        end
    end

    // pointers
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push_w)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (load_w)
                rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // registered head word
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end
        else if (load_w)
        begin
            out_valid_r <= 1'b1;
            out_data_r <= mem_r[rd_ptr_r[PW-1:0]];
        end
        else if (q.out_ready)
        begin
            out_valid_r <= 1'b0;
        end
    end
endmodule : psm_fifo

// ---- sim/psm_mem_model.sv ----
`timescale 1ns/1ps
module psm_mem_model
    import psm_pkg::*;
(
    // clock and settings
    input wire logic core_clk_in,
    input wire logic [CFG_W-1:0] cfg_in,
    // memory pins
    input wire logic clk_one_in,
    input wire logic clk_two_in,
    input wire logic cs_n_in,
    input wire logic [BE_W-1:0] be_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic stb_n_in,
    input wire logic we_n_in,
    input wire logic [DATA_W-1:0] wdata_in,
    // read data back
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] drv_r = 32'h5A5A5A5A;
    int tk = 0;
    int rd_due[$];
    logic [DATA_W-1:0] rd_dat[$];
    int wr_due[$];
    logic [3:0] wr_idx[$];
    logic [BE_W-1:0] wr_ben[$];
    wire sel = cfg_in[CFG_CLK_BIT] ? clk_two_in : clk_one_in;
    wire rd_cmd = !cs_n_in && !stb_n_in && we_n_in;
    wire wr_cmd = !cs_n_in && !stb_n_in && !we_n_in;
    wire [1:0] rl = cfg_in[CFG_RL_LSB +: 2];
    // flow-through for zero latency, otherwise the pipelined word
    assign rdata_out = (rd_cmd && rl == 2'h0) ? mem[addr_in[3:0]] : drv_r;
    initial foreach (mem[i]) mem[i] = '0;
    // pins as they stood before the edge; acts only if the chosen clock has just risen
    always @(posedge core_clk_in)
    begin
        logic was_hi;
        logic use_two;
        logic rd_c;
        logic wr_c;
        logic [3:0] a;
        logic [BE_W-1:0] bn;
        logic [DATA_W-1:0] wd;
        was_hi = sel;
        use_two = cfg_in[CFG_CLK_BIT];
        rd_c = rd_cmd;
        wr_c = wr_cmd;
        a = addr_in[3:0];
        bn = be_n_in;
        wd = wdata_in;
        #1;
        if (!was_hi && (use_two ? clk_two_in : clk_one_in))
        begin
            tk = tk + 1;
            if (wr_c)
            begin
                wr_due.push_back(tk + int'(cfg_in[CFG_WL_LSB +: 2]));
                wr_idx.push_back(a);
                wr_ben.push_back(bn);
            end
            // write data taken exactly at its due edge
            if (wr_due.size() > 0 && wr_due[0] == tk)
            begin
                for (int b = 0; b < BE_W; b++)
                    if (!wr_ben[0][b]) mem[wr_idx[0]][8*b +: 8] = wd[8*b +: 8];
                void'(wr_due.pop_front());
                void'(wr_idx.pop_front());
                void'(wr_ben.pop_front());
            end
            if (rd_c && rl != 2'h0)
            begin
                rd_due.push_back(tk + int'(rl));
                rd_dat.push_back(mem[a]);
            end
            // data valid only around its capture edge, junk otherwise
            if (rd_due.size() > 0 && rd_due[0] == tk + 1)
            begin
                drv_r <= rd_dat.pop_front();
                void'(rd_due.pop_front());
            end
            else
                drv_r <= ~rdata_out;
        end
    end
endmodule : psm_mem_model

// ---- sim/prog_sync_mem_interface_test.sv ----
`timescale 1ns/1ps
module prog_sync_mem_interface_test import psm_pkg::*;;
    logic core_clk_in, rst_in, cfg_load_in, cfg_ready_out, req_valid_in, req_write_in;
    logic req_ready_out, rd_valid_out, clk1, clk2, cs_n, stb_n, oe_n, we_n, d_oe;
    logic [CFG_W-1:0] cfg_in, cfg_now, cfg_reg;
    logic [ADDR_W-1:0] req_addr_in, ea;
    logic [BE_W-1:0] req_be_in, be_n;
    logic [DATA_W-1:0] req_data_in, rd_data_out, d_in, d_out;
    logic [DATA_W-1:0] ref_mem [16];
    logic [DATA_W-1:0] exp_q[$];
    integer seed = 32'h53F9F159;
    int fail_count = 0;
    int tests_run = 0;
    int refused = 0;
    psm_sync_mem_if dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .cfg_load_in(cfg_load_in), .cfg_in(cfg_in), .cfg_ready_out(cfg_ready_out),
        .space_secondary_control_out(cfg_reg), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_be_in(req_be_in),
        .req_data_in(req_data_in), .req_ready_out(req_ready_out),
        .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
        .ext_clock_out_one(clk1), .ext_clock_out_two(clk2), .chip_select_n_out(cs_n),
        .byte_enable_n_out(be_n), .ext_addr_bus_out(ea),
        .addr_strobe_or_read_en_n_out(stb_n), .sync_output_en_n_out(oe_n),
        .sync_write_en_n_out(we_n), .ext_data_bus_in(d_in), .ext_data_bus_out(d_out),
        .ext_data_bus_oe_out(d_oe));
    psm_mem_model mem (.core_clk_in(core_clk_in), .cfg_in(cfg_now), .clk_one_in(clk1),
        .clk_two_in(clk2), .cs_n_in(cs_n), .be_n_in(be_n), .addr_in(ea), .stb_n_in(stb_n),
        .we_n_in(we_n), .wdata_in(d_oe ? d_out : ~d_out), .rdata_out(d_in));
    // core clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    task automatic check_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : check_data
    task automatic check_cfg(input logic [CFG_W-1:0] got, input logic [CFG_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: settings %h expected %h", $time, got, exp);
        end
    endtask : check_cfg
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // one request word, held until the buffer takes it
    task automatic push(input logic wr, input logic [3:0] idx);
        int n;
        n = 0;
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_addr_in = 20'($random(seed));
        req_addr_in[3:0] = idx;
        req_be_in = 4'($random(seed));
        req_data_in = $random(seed);
        @(posedge core_clk_in);
        while (req_ready_out !== 1'b1 && n < 400)
        begin
            refused++;
            n++;
            @(posedge core_clk_in);
        end
        if (n == 400)
            fail_count++;
        if (wr)
        begin
            for (int b = 0; b < BE_W; b++)
                if (req_be_in[b]) ref_mem[idx][8*b +: 8] = req_data_in[8*b +: 8];
        end
        else
            exp_q.push_back(ref_mem[idx]);
        #1;
    endtask : push
    // waits for idle, then loads new settings
    task automatic load_cfg(input logic [CFG_W-1:0] v);
        int n;
        n = 0;
        req_valid_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        while (cfg_ready_out !== 1'b1 && n < 2000)
        begin
            n++;
            @(posedge core_clk_in);
        end
        #1;
        cfg_load_in = 1'b1;
        cfg_in = v;
        @(posedge core_clk_in);
        #1;
        cfg_load_in = 1'b0;
        cfg_now = v;
        check_cfg(cfg_reg, v);
    endtask : load_cfg
    // every read return against the reference order
    always @(posedge core_clk_in)
        if (rd_valid_out === 1'b1)
            check_data(rd_data_out, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data_out);
    // watchdog
    initial
    begin
        #5000000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end
    // main sequence
    initial
    begin
        foreach (ref_mem[i]) ref_mem[i] = '0;
        {cfg_load_in, req_valid_in, req_write_in, req_addr_in, req_be_in, req_data_in} = '0;
        cfg_in = '0;
        cfg_now = '0;
        rst_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        check_cfg(cfg_reg, CFG_RESET);
        for (int i = 0; i < 16; i++)
        begin
            load_cfg({3'($random(seed)), 4'(i)});
            repeat (8) push(1'($random(seed)), 4'($random(seed)));
            $display("config %0d done, read lat %0d write lat %0d", i, i % 4, i / 4);
        end
        // slowest clock, longest latencies, fifo mode: overfill the buffer
        load_cfg(7'h7F);
        refused = 0;
        repeat (24) push(1'b1, 4'($random(seed)));
        req_valid_in = 1'b0;
        cfg_load_in = 1'b1;
        cfg_in = 7'h00;
        @(posedge core_clk_in);
        #1;
        cfg_load_in = 1'b0;
        check_cfg(cfg_reg, 7'h7F);
        check_data(32'(refused > 0), 32'h00000001);
        for (int i = 0; i < 16; i++)
            push(1'b0, 4'(i));
        load_cfg(7'h00);
        repeat (4) @(posedge core_clk_in);
        check_data(32'(exp_q.size()), 32'h00000000);
        $display("buffer fill test done, %0d refusals", refused);
        print_verdict();
    end
endmodule : prog_sync_mem_interface_test
